/* File: inc/spe_pkg.sv */
package spe_pkg;

  // Instruction register width and opcodes
  localparam int IR_W = 4;
  localparam logic [3:0] IR_BYPASS = 4'hf;
  localparam logic [3:0] IR_IDCODE = 4'h1;
  localparam logic [3:0] IR_EMUCTL = 4'h2;
  // Opcode loaded in test-logic-reset
  localparam logic [3:0] IR_RESET = 4'h1;
  // Fixed pattern captured in capture-ir
  localparam logic [3:0] IR_CAPTURE = 4'h1;

  // Identity word width; the value itself is a top-level parameter
  localparam int ID_W = 32;

  // Emulation control register layout
  localparam int EMU_W = 4;
  localparam int EMU_A_EN = 0;
  localparam int EMU_A_VAL = 1;
  localparam int EMU_B_EN = 2;
  localparam int EMU_B_VAL = 3;
  localparam logic [3:0] EMU_RESET = 4'h0;

  // Positions in the pin synchroniser vector
  localparam int SYNC_W = 6;
  localparam int SI_TCK = 0;
  localparam int SI_TMS = 1;
  localparam int SI_TDI = 2;
  localparam int SI_TRST = 3;
  localparam int SI_EMU_A = 4;
  localparam int SI_EMU_B = 5;
  localparam logic [5:0] SYNC_RESET = 6'h00;

  // Sixteen test port controller states
  typedef enum logic [3:0] {
    ST_TLR, ST_RTI,
    ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
    ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR,
    ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } spe_tap_state_t;

endpackage : spe_pkg

/* File: inc/spe_tap_if.sv */
`timescale 1ns/1ps
// Link between pin logic and the controller state machine
interface spe_tap_if;
  logic step; // One mclk pulse per accepted rising test clock
  logic tms; // Synchronised mode select
  logic hold_rst; // Test reset held low
  spe_pkg::spe_tap_state_t state; // Current controller state

  modport fsm (input step, input tms, input hold_rst, output state);
  modport core (output step, output tms, output hold_rst, input state);
endinterface : spe_tap_if

/* File: hdl/spe_tap_fsm.sv */
`timescale 1ns/1ps
module spe_tap_fsm (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Controller link
  spe_tap_if.fsm tap
);

  ////////////////////////////////////////////////////////////////////////////
  // Next state from mode select
  function automatic spe_pkg::spe_tap_state_t spe_next(
    input spe_pkg::spe_tap_state_t s, input logic m);
    spe_pkg::spe_tap_state_t n;
    n = s;
    unique case (s)
      spe_pkg::ST_TLR: n = m ? spe_pkg::ST_TLR : spe_pkg::ST_RTI;
      spe_pkg::ST_RTI: n = m ? spe_pkg::ST_SEL_DR : spe_pkg::ST_RTI;
      spe_pkg::ST_SEL_DR: n = m ? spe_pkg::ST_SEL_IR : spe_pkg::ST_CAP_DR;
      spe_pkg::ST_CAP_DR: n = m ? spe_pkg::ST_EX1_DR : spe_pkg::ST_SH_DR;
      spe_pkg::ST_SH_DR: n = m ? spe_pkg::ST_EX1_DR : spe_pkg::ST_SH_DR;
      spe_pkg::ST_EX1_DR: n = m ? spe_pkg::ST_UPD_DR : spe_pkg::ST_PAU_DR;
      spe_pkg::ST_PAU_DR: n = m ? spe_pkg::ST_EX2_DR : spe_pkg::ST_PAU_DR;
      spe_pkg::ST_EX2_DR: n = m ? spe_pkg::ST_UPD_DR : spe_pkg::ST_SH_DR;
      spe_pkg::ST_UPD_DR: n = m ? spe_pkg::ST_SEL_DR : spe_pkg::ST_RTI;
      spe_pkg::ST_SEL_IR: n = m ? spe_pkg::ST_TLR : spe_pkg::ST_CAP_IR;
      spe_pkg::ST_CAP_IR: n = m ? spe_pkg::ST_EX1_IR : spe_pkg::ST_SH_IR;
      spe_pkg::ST_SH_IR: n = m ? spe_pkg::ST_EX1_IR : spe_pkg::ST_SH_IR;
      spe_pkg::ST_EX1_IR: n = m ? spe_pkg::ST_UPD_IR : spe_pkg::ST_PAU_IR;
      spe_pkg::ST_PAU_IR: n = m ? spe_pkg::ST_EX2_IR : spe_pkg::ST_PAU_IR;
      spe_pkg::ST_EX2_IR: n = m ? spe_pkg::ST_UPD_IR : spe_pkg::ST_SH_IR;
      spe_pkg::ST_UPD_IR: n = m ? spe_pkg::ST_SEL_DR : spe_pkg::ST_RTI;
    endcase
    return n;
  endfunction : spe_next

  ////////////////////////////////////////////////////////////////////////////
  // State register
  spe_pkg::spe_tap_state_t state_q; // Controller state
  spe_pkg::spe_tap_state_t state_d; // Next controller state

  // Held in reset while test reset is low; moves only on a test clock rise
  assign state_d = tap.hold_rst ? spe_pkg::ST_TLR // see R13
                 : tap.step ? spe_next(state_q, tap.tms) // see R13
                 : state_q;

  // State flop
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q <= spe_pkg::ST_TLR;
    end else begin
      state_q <= state_d;
    end
  end

  assign tap.state = state_q;

endmodule : spe_tap_fsm

/* File: hdl/spe_scan_port.sv */
`timescale 1ns/1ps
// How it works
// R1: TMS and TDI sampled on rising test clock
// R2: TDO changes only on falling test clock; the code releases the driver at once on leaving shift
// R3: TDO floats unless a shift is active
// R4: TDO floats while output disable is active
// R5: Test reset high hands control to scan
// R6: Test reset low ignores scan inputs
// R7: Pin a is scan-configured event line
// R8: Pin b is scan-configured event line
// R9: Test reset low makes pin b disable
// R10: Output disable floats every output driver
// R11: Disable needs reset low, a high, b low
// R12: Disable is for test and emulation only
// R13: Sixteen-state controller, reset when test reset low
module spe_scan_port #(
  // Identity word; value is arbitrary, bit 0 set
  parameter logic [31:0] ID_VALUE = 32'h5a5a_0001
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Test port pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst,
  output logic tdo_out,
  output logic tdo_oe_n,
  // Emulation pin a
  input wire logic emulation_event_pin_a_in,
  output logic emulation_event_pin_a_out,
  output logic emulation_event_pin_a_oe_n,
  // Emulation pin b, also the output disable
  input wire logic emulation_event_pin_b_or_output_disable_in,
  output logic emulation_event_pin_b_or_output_disable_out,
  output logic emulation_event_pin_b_or_output_disable_oe_n,
  // Core side
  input wire logic core_evt_a,
  input wire logic core_evt_b,
  output logic evt_a_seen,
  output logic evt_b_seen,
  output logic scan_mode,
  output logic outputs_off
);

  ////////////////////////////////////////////////////////////////////////////
  // Shift state decode, used by drive logic and checks
  function automatic logic spe_is_shift(input spe_pkg::spe_tap_state_t s);
    return (s == spe_pkg::ST_SH_DR) || (s == spe_pkg::ST_SH_IR);
  endfunction : spe_is_shift

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [spe_pkg::SYNC_W-1:0] sync_in; // Raw pin levels
  logic [spe_pkg::SYNC_W-1:0] sync1_q; // First stage, read only by stage two
  logic [spe_pkg::SYNC_W-1:0] sync2_q; // Safe to use
  logic tck_old_q; // Previous synced test clock

  assign sync_in[spe_pkg::SI_TCK] = tck;
  assign sync_in[spe_pkg::SI_TMS] = tms;
  assign sync_in[spe_pkg::SI_TDI] = tdi;
  assign sync_in[spe_pkg::SI_TRST] = trst;
  assign sync_in[spe_pkg::SI_EMU_A] = emulation_event_pin_a_in;
  assign sync_in[spe_pkg::SI_EMU_B] =
    emulation_event_pin_b_or_output_disable_in;

  // Two stages for every pin; all share one latency so TMS/TDI line up
  always_ff @(posedge mclk) begin
    if (srst) begin
      sync1_q <= spe_pkg::SYNC_RESET;
      sync2_q <= spe_pkg::SYNC_RESET;
      tck_old_q <= 1'b0;
    end else begin
      sync1_q <= sync_in;
      sync2_q <= sync1_q;
      tck_old_q <= sync2_q[spe_pkg::SI_TCK];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Synced levels and test clock edges
  logic tck_s; // Synced test clock
  logic tms_s; // Synced mode select
  logic tdi_s; // Synced data in
  logic trst_s; // Synced test reset
  logic emu_a_s; // Synced pin a
  logic emu_b_s; // Synced pin b
  logic rise_w; // Test clock rose
  logic fall_w; // Test clock fell
  logic step_w; // Accepted rise
  logic off_w; // Output disable condition

  assign tck_s = sync2_q[spe_pkg::SI_TCK];
  assign tms_s = sync2_q[spe_pkg::SI_TMS];
  assign tdi_s = sync2_q[spe_pkg::SI_TDI];
  assign trst_s = sync2_q[spe_pkg::SI_TRST];
  assign emu_a_s = sync2_q[spe_pkg::SI_EMU_A];
  assign emu_b_s = sync2_q[spe_pkg::SI_EMU_B];
  assign rise_w = tck_s & ~tck_old_q;
  assign fall_w = ~tck_s & tck_old_q;
  // Rises are dropped while test reset is low
  assign step_w = rise_w & trst_s; // see R1 see R6
  // Pin b read as active-low disable only in functional mode
  assign off_w = ~trst_s & emu_a_s & ~emu_b_s; // see R9 see R11

  ////////////////////////////////////////////////////////////////////////////
  // Controller state machine
  spe_tap_if tap_if ();
  spe_pkg::spe_tap_state_t st; // Current state

  assign tap_if.step = step_w;
  assign tap_if.tms = tms_s;
  assign tap_if.hold_rst = ~trst_s; // see R13
  assign st = tap_if.state;

  spe_tap_fsm u_fsm (
    .mclk (mclk),
    .srst (srst),
    .tap (tap_if.fsm)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State decode
  logic in_tlr; // Test logic reset
  logic cap_ir; // Capture-ir on this rise
  logic sh_ir; // Shift-ir on this rise
  logic upd_ir; // Update-ir on this rise
  logic cap_dr; // Capture-dr on this rise
  logic sh_dr; // Shift-dr on this rise
  logic upd_dr; // Update-dr on this rise

  assign in_tlr = (st == spe_pkg::ST_TLR);
  assign cap_ir = step_w & (st == spe_pkg::ST_CAP_IR);
  assign sh_ir = step_w & (st == spe_pkg::ST_SH_IR);
  assign upd_ir = step_w & (st == spe_pkg::ST_UPD_IR);
  assign cap_dr = step_w & (st == spe_pkg::ST_CAP_DR);
  assign sh_dr = step_w & (st == spe_pkg::ST_SH_DR);
  assign upd_dr = step_w & (st == spe_pkg::ST_UPD_DR);

  ////////////////////////////////////////////////////////////////////////////
  // Instruction register
  logic [spe_pkg::IR_W-1:0] ir_sh_q; // Instruction shift stage
  logic [spe_pkg::IR_W-1:0] ir_sh_d;
  logic [spe_pkg::IR_W-1:0] ir_q; // Active instruction
  logic [spe_pkg::IR_W-1:0] ir_d;
  logic sel_id; // Identity word selected
  logic sel_emu; // Emulation control selected

  // Shift in from TDI on the accepted rise
  assign ir_sh_d = cap_ir ? spe_pkg::IR_CAPTURE
                 : sh_ir ? {tdi_s, ir_sh_q[spe_pkg::IR_W-1:1]} // see R1
                 : ir_sh_q;
  assign ir_d = in_tlr ? spe_pkg::IR_RESET
              : upd_ir ? ir_sh_q
              : ir_q;
  // Unknown opcodes fall back to the one-bit bypass path
  assign sel_id = (ir_q == spe_pkg::IR_IDCODE);
  assign sel_emu = (ir_q == spe_pkg::IR_EMUCTL);

  // Instruction flops
  always_ff @(posedge mclk) begin
    if (srst) begin
      ir_sh_q <= spe_pkg::IR_CAPTURE;
      ir_q <= spe_pkg::IR_RESET;
    end else begin
      ir_sh_q <= ir_sh_d;
      ir_q <= ir_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data registers
  logic bypass_q; // Bypass bit
  logic bypass_d;
  logic [spe_pkg::ID_W-1:0] id_sh_q; // Identity shift stage
  logic [spe_pkg::ID_W-1:0] id_sh_d;
  logic [spe_pkg::EMU_W-1:0] emu_sh_q; // Emulation shift stage
  logic [spe_pkg::EMU_W-1:0] emu_sh_d;
  logic [spe_pkg::EMU_W-1:0] emu_cap; // Control with live pin levels
  logic [spe_pkg::EMU_W-1:0] emu_ctl_q; // Emulation pin direction control
  logic [spe_pkg::EMU_W-1:0] emu_ctl_d;

  // Capture shows pin levels in the value bits, enables as written
  assign emu_cap = {emu_b_s, emu_ctl_q[spe_pkg::EMU_B_EN],
                    emu_a_s, emu_ctl_q[spe_pkg::EMU_A_EN]};
  assign bypass_d = cap_dr ? 1'b0 : sh_dr ? tdi_s : bypass_q; // see R1
  assign id_sh_d = (cap_dr & sel_id) ? ID_VALUE
                 : (sh_dr & sel_id) ? {tdi_s, id_sh_q[spe_pkg::ID_W-1:1]}
                 : id_sh_q;
  assign emu_sh_d = (cap_dr & sel_emu) ? emu_cap
                  : (sh_dr & sel_emu)
                  ? {tdi_s, emu_sh_q[spe_pkg::EMU_W-1:1]}
                  : emu_sh_q;
  // Direction set through scan; cleared in test-logic-reset
  assign emu_ctl_d = in_tlr ? spe_pkg::EMU_RESET
                   : (upd_dr & sel_emu) ? emu_sh_q // see R7 see R8
                   : emu_ctl_q;

  // Data flops
  always_ff @(posedge mclk) begin
    if (srst) begin
      bypass_q <= 1'b0;
      id_sh_q <= ID_VALUE;
      emu_sh_q <= spe_pkg::EMU_RESET;
      emu_ctl_q <= spe_pkg::EMU_RESET;
    end else begin
      bypass_q <= bypass_d;
      id_sh_q <= id_sh_d;
      emu_sh_q <= emu_sh_d;
      emu_ctl_q <= emu_ctl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial data out
  logic tdo_bit; // Bit at the head of the selected path
  logic tdo_q;
  logic tdo_d;
  logic tdo_oe_n_q;
  logic tdo_oe_n_d;

  assign tdo_bit = (st == spe_pkg::ST_SH_IR) ? ir_sh_q[0]
                 : sel_id ? id_sh_q[0]
                 : sel_emu ? emu_sh_q[0]
                 : bypass_q;
  // Level taken only at a falling test clock
  assign tdo_d = fall_w ? tdo_bit : tdo_q; // see R2
  // Driver released at once on leaving shift; the real pin would wait
  // for the next fall, which costs a half clock of float early
  assign tdo_oe_n_d = (~spe_is_shift(st) | ~trst_s) ? 1'b1 // see R3
                    : off_w ? 1'b1 // see R4
                    : fall_w ? 1'b0 // see R2
                    : tdo_oe_n_q;

  // Output flops
  always_ff @(posedge mclk) begin
    if (srst) begin
      tdo_q <= 1'b0;
      tdo_oe_n_q <= 1'b1;
    end else begin
      tdo_q <= tdo_d;
      tdo_oe_n_q <= tdo_oe_n_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Emulation pins and core flags
  logic emu_a_out_q;
  logic emu_a_oe_n_q;
  logic emu_b_out_q;
  logic emu_b_oe_n_q;
  logic evt_a_q;
  logic evt_b_q;
  logic scan_q;
  logic off_q;
  logic emu_a_drv; // Pin a driven this cycle
  logic emu_b_drv; // Pin b driven this cycle

  // Drive only under scan control; pin b stays an input otherwise
  assign emu_a_drv = trst_s & emu_ctl_q[spe_pkg::EMU_A_EN]; // see R7
  assign emu_b_drv = trst_s & emu_ctl_q[spe_pkg::EMU_B_EN]; // see R8 see R9

  // Pin and flag flops
  always_ff @(posedge mclk) begin
    if (srst) begin
      emu_a_out_q <= 1'b0;
      emu_a_oe_n_q <= 1'b1;
      emu_b_out_q <= 1'b0;
      emu_b_oe_n_q <= 1'b1;
      evt_a_q <= 1'b0;
      evt_b_q <= 1'b0;
      scan_q <= 1'b0;
      off_q <= 1'b0;
    end else begin
      emu_a_out_q <= emu_ctl_q[spe_pkg::EMU_A_VAL] | core_evt_a;
      emu_a_oe_n_q <= ~(emu_a_drv & ~off_w);
      emu_b_out_q <= emu_ctl_q[spe_pkg::EMU_B_VAL] | core_evt_b;
      emu_b_oe_n_q <= ~(emu_b_drv & ~off_w);
      evt_a_q <= trst_s & emu_a_s; // see R7
      evt_b_q <= trst_s & emu_b_s; // see R8
      scan_q <= trst_s; // see R5
      off_q <= off_w; // see R10
    end
  end

  assign tdo_out = tdo_q;
  assign tdo_oe_n = tdo_oe_n_q;
  assign emulation_event_pin_a_out = emu_a_out_q;
  assign emulation_event_pin_a_oe_n = emu_a_oe_n_q;
  assign emulation_event_pin_b_or_output_disable_out = emu_b_out_q;
  assign emulation_event_pin_b_or_output_disable_oe_n = emu_b_oe_n_q;
  assign evt_a_seen = evt_a_q;
  assign evt_b_seen = evt_b_q;
  assign scan_mode = scan_q;
  assign outputs_off = off_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  property p_ir_shift;
    sh_ir |=> ir_sh_q[spe_pkg::IR_W-1] == $past(tdi_s);
  endproperty
  a_ir_shift: assert property (p_ir_shift) // see R1
    else $error("instruction shift missed data in");

  property p_tdo_on_fall;
    $changed(tdo_q) |-> $past(fall_w);
  endproperty
  a_tdo_on_fall: assert property (p_tdo_on_fall) // see R2
    else $error("data out changed away from a falling edge");

  property p_tdo_only_shift;
    !tdo_oe_n_q |-> $past(spe_is_shift(st)) && !$past(off_w);
  endproperty
  a_tdo_only_shift: assert property (p_tdo_only_shift) // see R3
    else $error("data out driven outside a shift");

  property p_tdo_off;
    off_w |=> tdo_oe_n_q;
  endproperty
  a_tdo_off: assert property (p_tdo_off) // see R4
    else $error("data out driven while disabled");

  property p_scan_step;
    step_w && !tms_s && in_tlr |=> st == spe_pkg::ST_RTI ##0 scan_q;
  endproperty
  a_scan_step: assert property (p_scan_step) // see R5
    else $error("controller did not leave reset under scan");

  property p_func_ignore;
    !trst_s |=> in_tlr && tdo_oe_n_q && emu_a_oe_n_q && !scan_q;
  endproperty
  a_func_ignore: assert property (p_func_ignore) // see R6
    else $error("scan logic active in functional mode");

  property p_emu_a_drive;
    trst_s && emu_ctl_q[spe_pkg::EMU_A_EN] |=> !emu_a_oe_n_q &&
      emu_a_out_q == $past(emu_ctl_q[spe_pkg::EMU_A_VAL] | core_evt_a);
  endproperty
  a_emu_a_drive: assert property (p_emu_a_drive) // see R7
    else $error("pin a not driven as configured");

  property p_emu_b_drive;
    trst_s && emu_ctl_q[spe_pkg::EMU_B_EN] |=> !emu_b_oe_n_q &&
      emu_b_out_q == $past(emu_ctl_q[spe_pkg::EMU_B_VAL] | core_evt_b);
  endproperty
  a_emu_b_drive: assert property (p_emu_b_drive) // see R8
    else $error("pin b not driven as configured");

  property p_b_input;
    !trst_s |=> emu_b_oe_n_q;
  endproperty
  a_b_input: assert property (p_b_input) // see R9
    else $error("pin b driven in functional mode");

  property p_outputs_off;
    off_w |=> outputs_off ##1 (outputs_off == $past(off_w));
  endproperty
  a_outputs_off: assert property (p_outputs_off) // see R10
    else $error("output disable not passed on");

  property p_exit_dr;
    step_w && tms_s && st == spe_pkg::ST_SH_DR |=> st == spe_pkg::ST_EX1_DR;
  endproperty
  a_exit_dr: assert property (p_exit_dr) // see R13
    else $error("shift-dr did not exit on mode select");

  c_emu_update: cover property (upd_dr && sel_emu);
  c_id_shift: cover property (sh_dr && sel_id);
  c_off: cover property (off_w ##1 outputs_off);
  c_tdo_drive: cover property (tdo_oe_n_q ##1 !tdo_oe_n_q);

endmodule : spe_scan_port

/* File: test/spe_scan_host.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// Behavioural scan controller on the far side of the test port
module spe_scan_host (
  // Clock
  input wire logic mclk,
  // Return path
  input wire logic tdo_out,
  input wire logic tdo_oe_n,
  // Test port drive
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst,
  // Emulation pin drive, en high while driving
  output logic a_val,
  output logic a_en,
  output logic b_val,
  output logic b_en
);
  // Idle: clock parked low, pulled-up lines high, test reset low
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    trst = 1'b0;
    a_val = 1'b0;
    a_en = 1'b0;
    b_val = 1'b0;
    b_en = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One test clock: low half sets up, sample output after the rise
  task automatic tick(input logic m, input logic d, output logic q,
                      output logic qe);
    @(posedge mclk);
    tms <= m;
    tdi <= d;
    tck <= 1'b0;
    repeat (4) @(posedge mclk);
    tck <= 1'b1;
    // Late sample, output changed on the fall well before
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    // A floating line has no pull; model it as the wrong level
    q = tdo_oe_n ? ~tdo_out : tdo_out;
    qe = tdo_oe_n;
    @(posedge mclk);
  endtask : tick

  ////////////////////////////////////////////////////////////////////////////
  // Full scan from reset or idle, back to idle, clock parked after
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout, output logic oe_bad);
    logic q;
    logic qe;
    dout = '0;
    oe_bad = 1'b0;
    tick(1'b0, 1'b1, q, qe);
    tick(1'b1, 1'b1, q, qe);
    // Instruction path takes one more select
    if (ir) begin
      tick(1'b1, 1'b1, q, qe);
    end
    tick(1'b0, 1'b1, q, qe);
    tick(1'b0, 1'b1, q, qe);
    // Last shift bit leaves with mode select high
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], q, qe);
      dout[i] = q;
      if (qe !== 1'b0) begin
        oe_bad = 1'b1;
      end
    end
    tick(1'b1, 1'b1, q, qe);
    tick(1'b0, 1'b1, q, qe);
    // Clock stands still between frames
    @(posedge mclk);
    tck <= 1'b0;
    tms <= 1'b1;
    tdi <= 1'b1;
    @(negedge mclk);
  endtask : scan

  ////////////////////////////////////////////////////////////////////////////
  // Static pin levels; disable only ever used for test
  task automatic pins(input logic t, input logic ae, input logic av,
                      input logic be, input logic bv);
    @(posedge mclk);
    trst <= t;
    a_en <= ae;
    a_val <= av;
    b_en <= be;
    b_val <= bv;
    // Room for two sync flops and the output flop
    repeat (6) @(posedge mclk);
    @(negedge mclk);
  endtask : pins
endmodule : spe_scan_host

/* File: test/tb_top.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the scan port
module tb_top;
  // Identity word, value arbitrary, bit 0 set
  localparam logic [31:0] ID_T = 32'h0c3e_9a71;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic core_evt_a = 1'b0;
  logic core_evt_b = 1'b0;
  int err_total = 0;
  int samples_checked = 0;
  logic tck, tms, tdi, trst, tdo_out, tdo_oe_n;
  logic a_val, a_en, b_val, b_en;
  logic a_out, a_oe_n, b_out, b_oe_n;
  logic evt_a_seen, evt_b_seen, scan_mode, outputs_off;
  // Pin levels: device wins, then host, else board pull-up
  wire a_lvl = !a_oe_n ? a_out : (a_en ? a_val : 1'b1);
  wire b_lvl = !b_oe_n ? b_out : (b_en ? b_val : 1'b1);

  // 10 MHz system clock
  always #50 mclk = ~mclk;

  spe_scan_host host (.mclk(mclk), .tdo_out(tdo_out), .tdo_oe_n(tdo_oe_n),
    .tck(tck), .tms(tms), .tdi(tdi), .trst(trst), .a_val(a_val),
    .a_en(a_en), .b_val(b_val), .b_en(b_en));

  spe_scan_port #(.ID_VALUE(ID_T)) dut (.mclk(mclk), .srst(srst),
    .tck(tck), .tms(tms), .tdi(tdi), .trst(trst), .tdo_out(tdo_out),
    .tdo_oe_n(tdo_oe_n), .emulation_event_pin_a_in(a_lvl),
    .emulation_event_pin_a_out(a_out),
    .emulation_event_pin_a_oe_n(a_oe_n),
    .emulation_event_pin_b_or_output_disable_in(b_lvl),
    .emulation_event_pin_b_or_output_disable_out(b_out),
    .emulation_event_pin_b_or_output_disable_oe_n(b_oe_n),
    .core_evt_a(core_evt_a), .core_evt_b(core_evt_b),
    .evt_a_seen(evt_a_seen), .evt_b_seen(evt_b_seen),
    .scan_mode(scan_mode), .outputs_off(outputs_off));

  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Verdict and end of run
  task automatic test_done();
    $display("mismatches %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////////
  // Quiet state after reset
  task automatic s_reset();
    chk("tdo_oe_n", 1, tdo_oe_n);
    chk("a_oe_n", 1, a_oe_n);
    chk("b_oe_n", 1, b_oe_n);
    chk("outputs_off", 0, outputs_off);
  endtask : s_reset

  // Identity read straight after controller reset
  task automatic s_idcode();
    logic [31:0] d;
    logic bad;
    host.pins(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    chk("scan_mode", 1, scan_mode);
    host.scan(1'b0, 32, 32'h0000_0000, d, bad);
    chk("idcode", ID_T, d);
    chk("oe during shift", 0, bad);
    chk("tdo_oe_n idle", 1, tdo_oe_n);
  endtask : s_idcode

  // Instruction load: capture pattern out, control opcode in
  task automatic s_ir();
    logic [31:0] d;
    logic bad;
    host.scan(1'b1, 4, {28'h0, spe_pkg::IR_EMUCTL}, d, bad);
    chk("ir capture", {28'h0, spe_pkg::IR_CAPTURE}, d);
    chk("oe during ir", 0, bad);
  endtask : s_ir

  // Emulation control: capture pin levels, then drive both pins
  task automatic s_emuctl();
    logic [31:0] d;
    logic bad;
    host.scan(1'b0, 4, 32'h0000_0007, d, bad);
    chk("emu capture", 32'h0000_000a, d);
    chk("a_oe_n", 0, a_oe_n);
    chk("a_out", 1, a_out);
    chk("b_oe_n", 0, b_oe_n);
    chk("b_out", 0, b_out);
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    chk("evt_a_seen", 1, evt_a_seen);
    chk("evt_b_seen", 0, evt_b_seen);
    // Core event ORs onto the driven value
    @(posedge mclk);
    core_evt_b <= 1'b1;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk("b_out core", 1, b_out);
    @(posedge mclk);
    core_evt_b <= 1'b0;
  endtask : s_emuctl

  // Bypass opcode: one-bit path, a zero captured ahead of the data
  task automatic s_bypass();
    logic [31:0] d;
    logic bad;
    host.scan(1'b1, 4, {28'h0, spe_pkg::IR_BYPASS}, d, bad);
    host.scan(1'b0, 8, 32'h0000_00a5, d, bad);
    chk("bypass", 32'h0000_004a, d);
    chk("oe during bypass", 0, bad);
  endtask : s_bypass

  // Functional mode, ignored test inputs and the output disable
  task automatic s_off();
    logic q;
    logic qe;
    host.pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    chk("scan_mode", 0, scan_mode);
    chk("a_oe_n", 1, a_oe_n);
    chk("b_oe_n", 1, b_oe_n);
    host.tick(1'b0, 1'b0, q, qe);
    host.tick(1'b0, 1'b0, q, qe);
    chk("tdo_oe_n", 1, qe);
    host.pins(1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
    chk("outputs_off", 1, outputs_off);
    chk("tdo_oe_n off", 1, tdo_oe_n);
    host.pins(1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    chk("off released", 0, outputs_off);
    host.pins(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    chk("off a low", 0, outputs_off);
    host.pins(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
    chk("off scan", 0, outputs_off);
    host.pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
  endtask : s_off

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    s_reset();
    s_idcode();
    s_ir();
    s_emuctl();
    s_bypass();
    s_off();
    // Test reset low must have restored the identity opcode
    s_idcode();
    test_done();
  end

  // Watchdog, far beyond the roughly one thousand cycles needed
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    $display("unexpected watchdog expected done seen hang");
    test_done();
  end
endmodule : tb_top
